// file: verilog/spes_pkg.sv
// Package: constants, register map and types for the serial ping event sync block
package spes_pkg;

  // Clock and PWM timing
  localparam int HCLK_FREQ_HZ = 100_000_000;
  localparam int HCLK_PERIOD_NS = 10;
  localparam int PWM_FREQ_HZ = 20_000;
  localparam int PWM_DUTY_PCT = 50;
  localparam int PWM_PERIOD_CYC = HCLK_FREQ_HZ / PWM_FREQ_HZ;
  localparam int REG_W = 16;
  localparam logic [REG_W-1:0] PERIOD_RST = REG_W'(PWM_PERIOD_CYC - 1);
  localparam logic [REG_W-1:0] CMP_RST = REG_W'(PWM_PERIOD_CYC * PWM_DUTY_PCT / 100);
  localparam logic [REG_W-1:0] CMPC_RST = 16'h0001;
  localparam logic [REG_W-1:0] MATCH_RST = 16'h0001;
  localparam logic [REG_W-1:0] REG_ZERO = 16'h0000;
  localparam logic [REG_W-1:0] REG_ONE = 16'h0001;

  // Transmit link clock, divided from hclk
  localparam int TX_CLK_PERIOD_NS = 80;
  localparam logic [2:0] TX_HALF_CYC = 3'(TX_CLK_PERIOD_NS / (2 * HCLK_PERIOD_NS));
  localparam logic [2:0] DIV_ZERO = 3'h0;
  localparam logic [2:0] DIV_ONE = 3'h1;

  // Frame layout: start bit, type, optional payload, msb first
  localparam int FRAME_TYPE_W = 4;
  localparam int FRAME_W = 1 + FRAME_TYPE_W + REG_W;
  localparam logic [FRAME_TYPE_W-1:0] FRAME_PING = 4'h0;
  localparam logic [FRAME_TYPE_W-1:0] FRAME_DATA = 4'h2;
  localparam logic [4:0] PING_LEN = 5'h05;
  localparam logic [4:0] DATA_LEN = 5'h15;
  localparam logic [4:0] TYPE_LAST = 5'h03;
  localparam logic [4:0] PAYLOAD_LAST = 5'h0f;
  localparam logic [4:0] CNT_ZERO = 5'h00;
  localparam logic [4:0] CNT_ONE = 5'h01;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PERIOD = 8'h04;
  localparam logic [7:0] OFS_CMPA = 8'h08;
  localparam logic [7:0] OFS_CMPB = 8'h0c;
  localparam logic [7:0] OFS_CMPC = 8'h10;
  localparam logic [7:0] OFS_MATCH = 8'h14;
  localparam logic [7:0] OFS_TXDATA = 8'h18;
  localparam logic [7:0] OFS_RXDATA = 8'h1c;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  localparam logic [7:0] OFS_PINGCNT = 8'h24;

  // Control fields
  localparam int CTRL_LINK_UP_BIT = 0;
  localparam int CTRL_LEAD_BIT = 1;
  localparam int CTRL_EDGE_FALL_BIT = 2;
  localparam int CTRL_FWD_EN_BIT = 3;
  localparam int CTRL_PRESCALE_LSB = 4;
  localparam int PRESCALE_W = 4;
  localparam logic [PRESCALE_W-1:0] PS_ZERO = 4'h0;
  localparam logic [PRESCALE_W-1:0] PS_ONE = 4'h1;

  // Status fields
  localparam int STAT_DELAY_ON_BIT = 0;
  localparam int STAT_TX_BUSY_BIT = 1;
  localparam int STAT_RX_NEW_BIT = 2;
  localparam int STAT_DELAY_CNT_LSB = 16;

  typedef enum logic [1:0] {RX_IDLE, RX_TYPE, RX_PAYLOAD} spes_rx_e;
  typedef enum logic [1:0] {TX_IDLE, TX_LOW, TX_HIGH} spes_tx_e;

endpackage

// file: verilog/spes_link_rx.sv
// Link receiver: frame decoder on the receive link clock
`timescale 1ns/1ps
`default_nettype none

module spes_link_rx (
  // Link clock domain
  input wire logic link_rx_clk,
  input wire logic hresetn,
  input wire logic link_rx_data,
  // Crossing outputs, toggles and a held word
  output logic ping_tgl,
  output logic data_tgl,
  output logic [spes_pkg::REG_W-1:0] rx_word
);

  typedef struct packed {
    spes_pkg::spes_rx_e st;
    logic [4:0] cnt;
    logic [spes_pkg::FRAME_TYPE_W-1:0] ftype;
    logic [spes_pkg::REG_W-1:0] shift;
    logic ping_tgl;
    logic data_tgl;
    logic [spes_pkg::REG_W-1:0] word;
  } spes_rx_s;

  spes_rx_s s_q;
  spes_rx_s s_d;

  // The link clock stops between frames, so each frame ends on its own last edge
  always_comb begin
    s_d = s_q;
    case (s_q.st)
      spes_pkg::RX_IDLE: begin
        s_d.cnt = spes_pkg::CNT_ZERO;
        if (link_rx_data) begin
          s_d.st = spes_pkg::RX_TYPE;
        end
      end
      spes_pkg::RX_TYPE: begin
        s_d.ftype = {s_q.ftype[spes_pkg::FRAME_TYPE_W-2:0], link_rx_data};
        s_d.cnt = s_q.cnt + spes_pkg::CNT_ONE;
        if (s_q.cnt == spes_pkg::TYPE_LAST) begin
          s_d.cnt = spes_pkg::CNT_ZERO;
          s_d.st = spes_pkg::RX_IDLE;
          if (s_d.ftype == spes_pkg::FRAME_PING) begin
            s_d.ping_tgl = ~s_q.ping_tgl;
          end else if (s_d.ftype == spes_pkg::FRAME_DATA) begin
            s_d.st = spes_pkg::RX_PAYLOAD;
          end
        end
      end
      spes_pkg::RX_PAYLOAD: begin
        s_d.shift = {s_q.shift[spes_pkg::REG_W-2:0], link_rx_data};
        s_d.cnt = s_q.cnt + spes_pkg::CNT_ONE;
        if (s_q.cnt == spes_pkg::PAYLOAD_LAST) begin
          s_d.word = s_d.shift;
          s_d.data_tgl = ~s_q.data_tgl;
          s_d.st = spes_pkg::RX_IDLE;
        end
      end
      default: begin
        s_d.st = spes_pkg::RX_IDLE;
      end
    endcase
  end

  always_ff @(posedge link_rx_clk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign ping_tgl = s_q.ping_tgl;
  assign data_tgl = s_q.data_tgl;
  assign rx_word = s_q.word;

endmodule // spes_link_rx

`default_nettype wire

// file: verilog/spes_top.sv
// Serial ping event sync: AHB-Lite registers, PWM timer, ping trigger, delay logic, link tx
//
// Overview of operation
// - Ping sync runs only once link is up
// - Lead sends short ping frames repeatedly
// - Ping triggered on selected compare edge
// - Trigger from channel C, programmable compare
// - Prescaler passes every Nth event, N<=15
// - Received ping forwarded to transmitter one cycle later
// - Delay counter counts to match, clears, stops
// - Ping starts counter; match emits sync-in
// - Sync-in only after match delay following ping
// - Period, A, B programmable; 50% at 20 kHz
// - Delay-logic output drives transmitter trigger
// - Pings and data share one clock, data line
`timescale 1ns/1ps
`default_nettype none

module spes_top (
  // Clocks and reset
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic link_rx_clk,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Receive link
  input wire logic link_rx_data,
  // Transmit link
  output logic link_tx_clk,
  output logic link_tx_data,
  // Local PWM timer
  output logic pwm_a,
  output logic pwm_b,
  output logic trigger_pwm_channel,
  output logic pwm_zero,
  output logic sync_in_pulse,
  output logic delay_logic_output
);

  typedef struct packed {
    logic [2:0] ping_sync;
    logic [2:0] data_sync;
    logic link_up;
    logic lead;
    logic edge_fall;
    logic fwd_en;
    logic [spes_pkg::PRESCALE_W-1:0] prescale;
    logic [spes_pkg::REG_W-1:0] period;
    logic [spes_pkg::REG_W-1:0] cmpa;
    logic [spes_pkg::REG_W-1:0] cmpb;
    logic [spes_pkg::REG_W-1:0] cmpc;
    logic [spes_pkg::REG_W-1:0] match;
    logic [spes_pkg::REG_W-1:0] pwm_cnt;
    logic pwm_a;
    logic pwm_b;
    logic pwm_c;
    logic pwm_zero;
    logic [spes_pkg::PRESCALE_W-1:0] ps_cnt;
    logic delay_on;
    logic [spes_pkg::REG_W-1:0] delay_cnt;
    logic sync_in;
    logic fwd;
    logic [spes_pkg::REG_W-1:0] ping_cnt;
    logic [spes_pkg::REG_W-1:0] rx_word;
    logic rx_new;
    spes_pkg::spes_tx_e tx_st;
    logic [spes_pkg::FRAME_W-1:0] tx_sh;
    logic [4:0] tx_left;
    logic [2:0] tx_div;
    logic tx_clk;
    logic pend_ping;
    logic pend_data;
    logic [spes_pkg::REG_W-1:0] tx_word;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
  } spes_state_s;

  spes_state_s s_q;
  spes_state_s s_d;

  logic ping_tgl;
  logic data_tgl;
  logic [spes_pkg::REG_W-1:0] rx_word;

  spes_link_rx u_rx (
    .link_rx_clk(link_rx_clk),
    .hresetn(hresetn),
    .link_rx_data(link_rx_data),
    .ping_tgl(ping_tgl),
    .data_tgl(data_tgl),
    .rx_word(rx_word)
  );

  logic ping_rx;
  logic data_rx;
  logic c_edge;
  logic lead_trig;
  logic tx_trig;
  logic acc;
  logic [31:0] rd;

  always_comb begin
    s_d = s_q;
    rd = '0;
    // Toggle crossings; only the second and third flops feed the edge detect
    s_d.ping_sync = {s_q.ping_sync[1:0], ping_tgl};
    s_d.data_sync = {s_q.data_sync[1:0], data_tgl};
    ping_rx = (s_q.ping_sync[2] ^ s_q.ping_sync[1]) & s_q.link_up;
    data_rx = s_q.data_sync[2] ^ s_q.data_sync[1];

    // PWM time base; a node's counter is pulled to zero by sync-in
    if (s_q.sync_in && !s_q.lead) begin
      s_d.pwm_cnt = spes_pkg::REG_ZERO;
    end else if (s_q.pwm_cnt >= s_q.period) begin
      s_d.pwm_cnt = spes_pkg::REG_ZERO;
    end else begin
      s_d.pwm_cnt = s_q.pwm_cnt + spes_pkg::REG_ONE;
    end
    s_d.pwm_a = s_d.pwm_cnt < s_q.cmpa;
    s_d.pwm_b = s_d.pwm_cnt < s_q.cmpb;
    s_d.pwm_c = s_d.pwm_cnt < s_q.cmpc;
    s_d.pwm_zero = s_d.pwm_cnt == spes_pkg::REG_ZERO;

    // Selected edge of channel C: rising at counter zero, falling at compare
    c_edge = s_q.edge_fall ? (s_q.pwm_c & ~s_d.pwm_c) : (~s_q.pwm_c & s_d.pwm_c);

    // Prescaler; zero disables lead pings, the 4-bit field caps N at 15
    lead_trig = 1'b0;
    if (s_q.lead && s_q.link_up && c_edge && s_q.prescale != spes_pkg::PS_ZERO) begin
      if (s_q.ps_cnt + spes_pkg::PS_ONE >= s_q.prescale) begin
        s_d.ps_cnt = spes_pkg::PS_ZERO;
        lead_trig = 1'b1;
      end else begin
        s_d.ps_cnt = s_q.ps_cnt + spes_pkg::PS_ONE;
      end
    end

    // Node forwarding path, one cycle after the ping is seen
    s_d.fwd = ping_rx & ~s_q.lead & s_q.fwd_en;
    tx_trig = lead_trig | s_q.fwd;

    // Delay counter and state bit
    s_d.sync_in = 1'b0;
    if (s_q.delay_on) begin
      if (s_q.delay_cnt == s_q.match) begin
        s_d.delay_on = 1'b0;
        s_d.delay_cnt = spes_pkg::REG_ZERO;
        s_d.sync_in = 1'b1;
      end else begin
        s_d.delay_cnt = s_q.delay_cnt + spes_pkg::REG_ONE;
      end
    end
    // A ping in the match cycle restarts the delay: set wins
    if (ping_rx && !s_q.lead) begin
      s_d.delay_on = 1'b1;
    end
    if (ping_rx) begin
      s_d.ping_cnt = s_q.ping_cnt + spes_pkg::REG_ONE;
    end

    // Transmit serializer; the link clock idles low between frames
    case (s_q.tx_st)
      spes_pkg::TX_IDLE: begin
        s_d.tx_clk = 1'b0;
        s_d.tx_div = spes_pkg::DIV_ZERO;
        if (s_q.pend_ping) begin
          // Pings go ahead of queued data to keep sync latency short
          s_d.tx_sh = {1'b1, spes_pkg::FRAME_PING, spes_pkg::REG_ZERO};
          s_d.tx_left = spes_pkg::PING_LEN;
          s_d.pend_ping = 1'b0;
          s_d.tx_st = spes_pkg::TX_LOW;
        end else if (s_q.pend_data) begin
          s_d.tx_sh = {1'b1, spes_pkg::FRAME_DATA, s_q.tx_word};
          s_d.tx_left = spes_pkg::DATA_LEN;
          s_d.pend_data = 1'b0;
          s_d.tx_st = spes_pkg::TX_LOW;
        end
      end
      spes_pkg::TX_LOW: begin
        if (s_q.tx_div == spes_pkg::TX_HALF_CYC - spes_pkg::DIV_ONE) begin
          s_d.tx_div = spes_pkg::DIV_ZERO;
          s_d.tx_clk = 1'b1;
          s_d.tx_st = spes_pkg::TX_HIGH;
        end else begin
          s_d.tx_div = s_q.tx_div + spes_pkg::DIV_ONE;
        end
      end
      spes_pkg::TX_HIGH: begin
        if (s_q.tx_div == spes_pkg::TX_HALF_CYC - spes_pkg::DIV_ONE) begin
          s_d.tx_div = spes_pkg::DIV_ZERO;
          s_d.tx_clk = 1'b0;
          s_d.tx_sh = {s_q.tx_sh[spes_pkg::FRAME_W-2:0], 1'b0};
          s_d.tx_left = s_q.tx_left - spes_pkg::CNT_ONE;
          s_d.tx_st = (s_q.tx_left == spes_pkg::CNT_ONE) ? spes_pkg::TX_IDLE : spes_pkg::TX_LOW;
        end else begin
          s_d.tx_div = s_q.tx_div + spes_pkg::DIV_ONE;
        end
      end
      default: begin
        s_d.tx_st = spes_pkg::TX_IDLE;
      end
    endcase
    if (tx_trig) begin
      s_d.pend_ping = 1'b1;
    end

    // Bus data phase of a write
    if (s_q.wr_pend) begin
      case (s_q.wr_addr)
        spes_pkg::OFS_CTRL: begin
          s_d.link_up = hwdata[spes_pkg::CTRL_LINK_UP_BIT];
          s_d.lead = hwdata[spes_pkg::CTRL_LEAD_BIT];
          s_d.edge_fall = hwdata[spes_pkg::CTRL_EDGE_FALL_BIT];
          s_d.fwd_en = hwdata[spes_pkg::CTRL_FWD_EN_BIT];
          s_d.prescale = hwdata[spes_pkg::CTRL_PRESCALE_LSB +: spes_pkg::PRESCALE_W];
        end
        spes_pkg::OFS_PERIOD: s_d.period = hwdata[spes_pkg::REG_W-1:0];
        spes_pkg::OFS_CMPA: s_d.cmpa = hwdata[spes_pkg::REG_W-1:0];
        spes_pkg::OFS_CMPB: s_d.cmpb = hwdata[spes_pkg::REG_W-1:0];
        spes_pkg::OFS_CMPC: s_d.cmpc = hwdata[spes_pkg::REG_W-1:0];
        spes_pkg::OFS_MATCH: s_d.match = hwdata[spes_pkg::REG_W-1:0];
        spes_pkg::OFS_TXDATA: begin
          s_d.tx_word = hwdata[spes_pkg::REG_W-1:0];
          s_d.pend_data = 1'b1;
        end
        default: begin
        end
      endcase
    end

    // Address phase; writable registers read from next state so a write just before is seen
    acc = hsel & htrans[1] & hready;
    s_d.wr_pend = acc & hwrite;
    s_d.wr_addr = haddr[7:0];
    case (haddr[7:0])
      spes_pkg::OFS_CTRL: begin
        rd[spes_pkg::CTRL_LINK_UP_BIT] = s_d.link_up;
        rd[spes_pkg::CTRL_LEAD_BIT] = s_d.lead;
        rd[spes_pkg::CTRL_EDGE_FALL_BIT] = s_d.edge_fall;
        rd[spes_pkg::CTRL_FWD_EN_BIT] = s_d.fwd_en;
        rd[spes_pkg::CTRL_PRESCALE_LSB +: spes_pkg::PRESCALE_W] = s_d.prescale;
      end
      spes_pkg::OFS_PERIOD: rd[spes_pkg::REG_W-1:0] = s_d.period;
      spes_pkg::OFS_CMPA: rd[spes_pkg::REG_W-1:0] = s_d.cmpa;
      spes_pkg::OFS_CMPB: rd[spes_pkg::REG_W-1:0] = s_d.cmpb;
      spes_pkg::OFS_CMPC: rd[spes_pkg::REG_W-1:0] = s_d.cmpc;
      spes_pkg::OFS_MATCH: rd[spes_pkg::REG_W-1:0] = s_d.match;
      spes_pkg::OFS_TXDATA: rd[spes_pkg::REG_W-1:0] = s_d.tx_word;
      spes_pkg::OFS_RXDATA: rd[spes_pkg::REG_W-1:0] = s_q.rx_word;
      spes_pkg::OFS_STATUS: begin
        rd[spes_pkg::STAT_DELAY_ON_BIT] = s_q.delay_on;
        rd[spes_pkg::STAT_TX_BUSY_BIT] = s_q.pend_ping | s_q.pend_data |
                                         (s_q.tx_st != spes_pkg::TX_IDLE);
        rd[spes_pkg::STAT_RX_NEW_BIT] = s_q.rx_new;
        rd[spes_pkg::STAT_DELAY_CNT_LSB +: spes_pkg::REG_W] = s_q.delay_cnt;
      end
      spes_pkg::OFS_PINGCNT: rd[spes_pkg::REG_W-1:0] = s_q.ping_cnt;
      default: rd = '0;
    endcase
    if (acc && !hwrite) begin
      s_d.rdata = rd;
      if (haddr[7:0] == spes_pkg::OFS_RXDATA) begin
        s_d.rx_new = 1'b0;
      end
    end
    // A word arriving as software reads the last one keeps its flag
    if (data_rx) begin
      s_d.rx_word = rx_word;
      s_d.rx_new = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
      s_q.period <= spes_pkg::PERIOD_RST;
      s_q.cmpa <= spes_pkg::CMP_RST;
      s_q.cmpb <= spes_pkg::CMP_RST;
      s_q.cmpc <= spes_pkg::CMPC_RST;
      s_q.match <= spes_pkg::MATCH_RST;
      s_q.tx_st <= spes_pkg::TX_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // Zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s_q.rdata;
  assign link_tx_clk = s_q.tx_clk;
  assign link_tx_data = s_q.tx_sh[spes_pkg::FRAME_W-1];
  assign pwm_a = s_q.pwm_a;
  assign pwm_b = s_q.pwm_b;
  assign trigger_pwm_channel = s_q.pwm_c;
  assign pwm_zero = s_q.pwm_zero;
  assign sync_in_pulse = s_q.sync_in;
  assign delay_logic_output = s_q.fwd;

endmodule // spes_top

`default_nettype wire

// file: test/spes_top_assertions.sv
// Checker: port properties of the ping sync block
`timescale 1ns/1ps
`default_nettype none

module spes_top_assertions (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Link and timer outputs
  input wire logic link_tx_clk,
  input wire logic link_tx_data,
  input wire logic pwm_a,
  input wire logic pwm_b,
  input wire logic pwm_zero,
  input wire logic sync_in_pulse,
  input wire logic delay_logic_output
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_SYNC_PULSE: assert property (sync_in_pulse |=> !sync_in_pulse)
    else $error("sync pulse wider than one cycle");
  AST_SYNC_RESTARTS_PWM: assert property (sync_in_pulse |-> ##[0:2] pwm_zero)
    else $error("sync pulse did not restart the timer");
  // Match resets to one and the test writes only 1 and 20, so sync never follows the forward pulse directly
  AST_SYNC_NOT_EARLY: assert property (delay_logic_output |=> !sync_in_pulse)
    else $error("sync pulse without match delay");
  AST_FWD_PULSE: assert property (delay_logic_output |=> !delay_logic_output)
    else $error("forward pulse wider than one cycle");
  // Bound covers a data frame already on the wire
  AST_FWD_STARTS_TX: assert property (delay_logic_output |-> ##[1:180] (link_tx_data && !link_tx_clk))
    else $error("forward pulse did not start a frame");
  AST_TX_CLK_HIGH: assert property ($rose(link_tx_clk) |-> link_tx_clk [*4] ##1 !link_tx_clk)
    else $error("link clock high phase not four cycles");
  AST_TX_CLK_LOW: assert property ($fell(link_tx_clk) |-> !link_tx_clk [*4])
    else $error("link clock low phase too short");
  AST_TX_DATA_STEADY: assert property (link_tx_clk |-> $stable(link_tx_data))
    else $error("link data moved while clock high");
  AST_PWM_ZERO_PULSE: assert property (pwm_zero |=> !pwm_zero)
    else $error("zero flag wider than one cycle");
  AST_PWM_HIGH_AT_ZERO: assert property (pwm_zero |-> pwm_a && pwm_b)
    else $error("pwm outputs low at counter zero");
endmodule // spes_top_assertions
`default_nettype wire

// file: test/spes_chain_model.sv
// Partner: upstream ping sender and downstream frame decoder
`timescale 1ns/1ps
`default_nettype none

module spes_chain_model (
  // Upstream sender
  output logic link_rx_clk,
  output logic link_rx_data,
  // Downstream receiver
  input wire logic link_tx_clk,
  input wire logic link_tx_data,
  // Traffic seen downstream
  output logic [15:0] ping_cnt,
  output logic [15:0] data_cnt,
  output logic [15:0] last_word
);
  logic busy;
  logic [19:0] sh;
  int nb;

  initial begin
    link_rx_clk = 1'b0;
    link_rx_data = 1'b1;
    ping_cnt = 16'h0;
    data_cnt = 16'h0;
    last_word = 16'h0;
    busy = 1'b0;
    sh = 20'h0;
    nb = 0;
  end

  // Clock runs only inside a frame; a trailing low bit keeps frames apart
  task automatic send_frame(input logic [3:0] ftype, input logic [15:0] word);
    logic [21:0] bits;
    int n;
    bits = (ftype == spes_pkg::FRAME_DATA) ? {1'b1, ftype, word, 1'b0} : {1'b1, ftype, 17'h0};
    n = (ftype == spes_pkg::FRAME_DATA) ? 22 : 6;
    for (int i = 0; i < n; i++) begin
      link_rx_data = bits[21 - i];
      #62.5;
      link_rx_clk = 1'b1;
      #62.5;
      link_rx_clk = 1'b0;
    end
    // Released line shows the inverse of the idle bit
    link_rx_data = 1'b1;
  endtask

  // Start bit, four type bits, payload only for data frames
  always @(posedge link_tx_clk) begin
    if (!busy) begin
      busy = link_tx_data;
      nb = 0;
    end else begin
      sh = {sh[18:0], link_tx_data};
      nb++;
      if (nb == 4 && sh[3:0] == spes_pkg::FRAME_PING) begin
        ping_cnt++;
        busy = 1'b0;
      end else if (nb == 4 && sh[3:0] != spes_pkg::FRAME_DATA) begin
        busy = 1'b0;
      end else if (nb == 20) begin
        data_cnt++;
        last_word = sh[15:0];
        busy = 1'b0;
      end
    end
  end
endmodule // spes_chain_model
`default_nettype wire

// file: test/testbench.sv
// Testbench: bus, link and timer scenarios for the ping sync block
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, link_rx_clk, link_rx_data, link_tx_clk, link_tx_data;
  logic [31:0] hrdata;
  logic pwm_a, pwm_b, trig_c, pwm_zero, sync_in_pulse, delay_logic_output;
  logic [15:0] ping_cnt, data_cnt, last_word;
  int errors = 0;
  int cmp_count = 0;

  always #5 hclk = ~hclk;

  spes_top u_spes_top (.hclk(hclk), .hresetn(hresetn), .link_rx_clk(link_rx_clk),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .link_rx_data(link_rx_data), .link_tx_clk(link_tx_clk),
    .link_tx_data(link_tx_data), .pwm_a(pwm_a), .pwm_b(pwm_b), .trigger_pwm_channel(trig_c),
    .pwm_zero(pwm_zero), .sync_in_pulse(sync_in_pulse),
    .delay_logic_output(delay_logic_output));

  spes_chain_model u_spes_chain_model (.link_rx_clk(link_rx_clk),
    .link_rx_data(link_rx_data), .link_tx_clk(link_tx_clk), .link_tx_data(link_tx_data),
    .ping_cnt(ping_cnt), .data_cnt(data_cnt), .last_word(last_word));

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    $display("Comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(1'b1, a, d, x);
  endtask

  task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    xfer(1'b0, a, 32'h0, x);
    check(n, x, e);
  endtask

  // Returns at the edge that closes a counter-zero cycle
  task automatic wait_zero;
    int i;
    i = 0;
    do begin @(posedge hclk); i++; end while (pwm_zero !== 1'b1 && i < 300);
    // A zero cycle that never comes is a hang of the time base
    if (pwm_zero !== 1'b1) errors++;
  endtask

  task automatic t_regs;
    rd_chk("period_rst", spes_pkg::OFS_PERIOD, 32'h1387);
    // Short period early, before the counter can pass it
    wr(spes_pkg::OFS_PERIOD, 32'h63);
    rd_chk("period", spes_pkg::OFS_PERIOD, 32'h63);
    rd_chk("cmpa_rst", spes_pkg::OFS_CMPA, 32'h9c4);
    rd_chk("cmpb_rst", spes_pkg::OFS_CMPB, 32'h9c4);
    rd_chk("cmpc_rst", spes_pkg::OFS_CMPC, 32'h1);
    rd_chk("match_rst", spes_pkg::OFS_MATCH, 32'h1);
    rd_chk("ctrl_rst", spes_pkg::OFS_CTRL, 32'h0);
    rd_chk("unmapped", 8'h3c, 32'h0);
    check("hresp_okay", hresp, 32'h0);
  endtask

  task automatic t_pwm;
    int per, ha, hb, hc;
    wr(spes_pkg::OFS_CMPA, 32'h32);
    wr(spes_pkg::OFS_CMPB, 32'h19);
    wait_zero();
    per = 0;
    ha = 0;
    hb = 0;
    hc = 0;
    do begin
      @(posedge hclk);
      per++;
      ha += int'(pwm_a);
      hb += int'(pwm_b);
      hc += int'(trig_c);
    end while (pwm_zero !== 1'b1 && per < 300);
    check("pwm_period", per, 32'h64);
    check("pwm_a_high", ha, 32'h32);
    check("pwm_b_high", hb, 32'h19);
    // Channel C still at its reset compare of one: high only in the zero cycle
    check("pwm_c_high", hc, 32'h1);
  endtask

  task automatic t_link_down;
    logic [15:0] p0;
    int seen;
    wr(spes_pkg::OFS_CTRL, 32'h8);
    p0 = ping_cnt;
    seen = 0;
    fork
      u_spes_chain_model.send_frame(spes_pkg::FRAME_PING, 16'h0);
      repeat (150) begin
        @(posedge hclk);
        if (delay_logic_output !== 1'b0 || sync_in_pulse !== 1'b0) seen++;
      end
    join
    check("fwd_link_down", seen, 32'h0);
    check("ping_link_down", ping_cnt, p0);
  endtask

  task automatic t_node;
    int n;
    logic [15:0] p0;
    logic [31:0] m;
    wr(spes_pkg::OFS_CTRL, 32'h9);
    for (int k = 0; k < 2; k++) begin
      m = (k == 0) ? 32'h1 : 32'h14;
      wr(spes_pkg::OFS_MATCH, m);
      p0 = ping_cnt;
      fork
        u_spes_chain_model.send_frame(spes_pkg::FRAME_PING, 16'h0);
      join_none
      n = 0;
      do begin @(posedge hclk); n++; end while (delay_logic_output !== 1'b1 && n < 300);
      n = 0;
      do begin @(posedge hclk); n++; end while (sync_in_pulse !== 1'b1 && n < 100);
      check("sync_delay", n, m + 32'h1);
      // The node's zero event lands one cycle after sync-in, where match places it
      @(posedge hclk);
      check("zero_at_sync", pwm_zero, 32'h1);
      n = 0;
      repeat (80) begin
        @(posedge hclk);
        if (sync_in_pulse === 1'b1) n++;
      end
      check("single_sync", n, 32'h0);
      wait fork;
      check("ping_fwd", ping_cnt, p0 + 16'h1);
      rd_chk("delay_idle", spes_pkg::OFS_STATUS, 32'h0);
    end
  endtask

  task automatic t_data;
    logic [15:0] d0;
    int n;
    wr(spes_pkg::OFS_CTRL, 32'h1);
    d0 = data_cnt;
    wr(spes_pkg::OFS_TXDATA, 32'ha5c3);
    n = 0;
    while (data_cnt == d0 && n < 400) begin
      @(posedge hclk);
      n++;
    end
    check("tx_word", last_word, 32'ha5c3);
    u_spes_chain_model.send_frame(spes_pkg::FRAME_DATA, 16'h3c5a);
    repeat (10) @(posedge hclk);
    rd_chk("rx_new", spes_pkg::OFS_STATUS, 32'h4);
    rd_chk("rx_word", spes_pkg::OFS_RXDATA, 32'h3c5a);
  endtask

  task automatic t_lead;
    logic [3:0] ps [4] = '{4'h1, 4'h1, 4'hf, 4'h3};
    logic fe [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
    logic [15:0] p0;
    int n;
    wr(spes_pkg::OFS_CMPC, 32'ha);
    for (int i = 0; i < 4; i++) begin
      wr(spes_pkg::OFS_CTRL, {24'h0, ps[i], 1'b0, fe[i], 2'h3});
      wait_zero();
      p0 = ping_cnt;
      repeat (2 * int'(ps[i])) wait_zero();
      check("lead_pings", ping_cnt - p0, 32'h2);
      if (ps[i] == 4'h1) begin
        n = 0;
        do begin @(posedge hclk); n++; end while (link_tx_data !== 1'b1 && n < 200);
        check("ping_phase", {31'h0, n > 7}, {31'h0, fe[i]});
      end
    end
    wr(spes_pkg::OFS_CTRL, 32'h0);
  endtask

  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_pwm();
    t_link_down();
    t_node();
    t_data();
    t_lead();
    report_and_stop();
  end

  // About six thousand cycles expected; nearly seven times that means a hang
  initial begin
    #400000;
    errors++;
    report_and_stop();
  end
endmodule // testbench

bind spes_top spes_top_assertions u_spes_top_assertions (.hclk(hclk), .hresetn(hresetn),
  .link_tx_clk(link_tx_clk), .link_tx_data(link_tx_data), .pwm_a(pwm_a), .pwm_b(pwm_b),
  .pwm_zero(pwm_zero), .sync_in_pulse(sync_in_pulse),
  .delay_logic_output(delay_logic_output));
`default_nettype wire
